// >>> hdl/led_pump_ctrl.sv
/*
  Control logic of a dual-channel LED driver with a multimode charge pump:
  pin synchronisers, two strobe channels, shutdown and wake handling, pump
  mode sequencer with soft start, and flying capacitor switch timing.
  Assumes comparators for dropout, overcurrent, pump output above battery
  and sink-tied-to-pump arrive as asynchronous levels; analog is external.
*/
module led_pump_ctrl
  import led_pump_pkg::*;
#(
  parameter int PUMP_PERIOD = PUMP_PERIOD_CYC,
  parameter int COMMIT      = COMMIT_TICKS,
  parameter int WAKE        = WAKE_TICKS,
  parameter int MODE_DELAY  = MODE_TICKS,
  parameter int SOFT_START  = SOFT_TICKS
)
(
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rstn,
  // Strobe enable pins
  input  wire logic                   main_strobe_enable,
  input  wire logic                   cam_strobe_enable,
  // Comparator flags
  input  wire logic [MAIN_SINKS-1:0]  main_sink_dropout,
  input  wire logic                   cam_sink_dropout,
  input  wire logic                   main_set_overcurrent,
  input  wire logic                   cam_set_overcurrent,
  input  wire logic                   pump_output_above_battery,
  input  wire logic [MAIN_SINKS-1:0]  main_sink_tied_to_pump,
  // Current sink control
  output logic [DAC_W-1:0]            main_dac_code,
  output logic [MAIN_SINKS-1:0]       main_sink_enable,
  output logic [MAIN_SINKS-1:0]       main_sink_test_current,
  output logic [DAC_W-1:0]            cam_dac_code,
  // Pump control
  output led_pump_pkg::pump_mode_t    pump_mode,
  output logic [STRENGTH_W-1:0]       pump_strength,
  output logic                        battery_bypass,
  output logic                        caps_series_charge,
  output logic                        caps_parallel_stack,
  output logic                        flying_cap1_charge,
  output logic                        flying_cap2_charge,
  // Power state
  output logic                        shutdown,
  output logic                        weak_precharge,
  output logic                        reference_enable
);
  import led_pump_pkg::*;

  localparam logic [TIMER_W-1:0]    MODE_LAST = TIMER_W'(MODE_DELAY - 1);
  localparam logic [STRENGTH_W-1:0] SOFT_FULL = STRENGTH_W'(SOFT_START);

  typedef struct packed {
    logic [IN_W-1:0]       sync1;
    logic [IN_W-1:0]       sync2;
    logic [IN_W-1:0]       sync3;
    logic [IN_W-1:0]       lvl;
    logic                  cam_line_d;
    logic                  asleep;
    logic                  wake;
    pump_mode_t            mode;
    logic [TIMER_W-1:0]    mode_timer;
    logic [STRENGTH_W-1:0] strength;
    logic [DAC_W-1:0]      main_code;
    logic [DAC_W-1:0]      cam_code;
    logic [MAIN_SINKS-1:0] sink_en;
    logic [MAIN_SINKS-1:0] test_cur;
    logic                  bypass;
    logic                  precharge;
    logic                  ref_en;
    logic                  series;
    logic                  parallel;
    logic                  cap1;
    logic                  cap2;
  } top_state_t;

  top_state_t s;
  top_state_t next_s;

  logic [IN_W-1:0]       raw_in;
  logic [DAC_W-1:0]      ch_main_code;
  logic [DAC_W-1:0]      ch_cam_code;
  logic                  ch_main_idle;
  logic                  ch_cam_idle;
  logic                  ph1;
  logic                  ph2;
  logic                  tick;
  logic                  main_line;
  logic                  cam_line;
  logic                  overcurrent;
  logic                  dropout;
  logic [MAIN_SINKS-1:0] tied;

  // ----------------------------------------------------------------------
  // Pin synchronisers: a change counts once stages two and three agree
  // ----------------------------------------------------------------------
  assign raw_in = {main_sink_tied_to_pump, pump_output_above_battery,
                   cam_set_overcurrent, main_set_overcurrent,
                   cam_sink_dropout, main_sink_dropout,
                   cam_strobe_enable, main_strobe_enable};

  assign main_line   = s.lvl[IDX_MAIN_EN];
  assign cam_line    = s.lvl[IDX_CAM_EN];
  assign overcurrent = s.lvl[IDX_MAIN_OVC] | s.lvl[IDX_CAM_OVC];
  assign tied        = s.lvl[IDX_TIED +: MAIN_SINKS];
  assign dropout     =
    |(s.lvl[IDX_MAIN_DROP +: MAIN_SINKS] & s.sink_en)
    | (s.lvl[IDX_CAM_DROP] & (s.cam_code != DAC_OFF));

  // ----------------------------------------------------------------------
  // Channels and pump clock
  // ----------------------------------------------------------------------
  strobe_channel #(
    .COMMIT      (COMMIT),
    .WAKE        (WAKE)
  ) u_main_chan (
    .clock       (clock),
    .rstn        (rstn),
    .line        (main_line),
    .tick        (tick),
    .extra_delay (s.wake),
    .force_off   (s.asleep),
    .dac_code    (ch_main_code),
    .idle_long   (ch_main_idle)
  );

  strobe_channel #(
    .COMMIT      (COMMIT),
    .WAKE        (WAKE)
  ) u_cam_chan (
    .clock       (clock),
    .rstn        (rstn),
    .line        (cam_line),
    .tick        (tick),
    .extra_delay (s.wake),
    .force_off   (s.asleep),
    .dac_code    (ch_cam_code),
    .idle_long   (ch_cam_idle)
  );

  pump_phase_gen #(
    .PERIOD (PUMP_PERIOD),
    .DEAD   (NONOVERLAP_CYC)
  ) u_phase (
    .clock  (clock),
    .rstn   (rstn),
    .run    (!s.asleep),
    .phase1 (ph1),
    .phase2 (ph2),
    .tick   (tick)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_s            = s;
    next_s.sync1      = raw_in;
    next_s.sync2      = s.sync1;
    next_s.sync3      = s.sync2;
    next_s.lvl        = (~(s.sync2 ^ s.sync3) & s.sync3)
                      | ((s.sync2 ^ s.sync3) & s.lvl);
    next_s.cam_line_d = cam_line;

    // Power state
    next_s.asleep = overcurrent
                  | (ch_main_idle & ch_cam_idle);
    if (s.asleep && !next_s.asleep)
      next_s.wake = 1'b1;
    else if (ch_main_code != DAC_OFF || ch_cam_code != DAC_OFF)
      next_s.wake = 1'b0;

    // Mode sequencer
    if (s.asleep || (s.cam_line_d && !cam_line))
    begin
      next_s.mode       = PUMP_1X;
      next_s.mode_timer = '0;
      next_s.strength   = '0;
    end
    else
    begin
      if (dropout && s.mode != PUMP_2X)
      begin
        if (tick)
        begin
          if (s.mode_timer >= MODE_LAST)
          begin
            next_s.mode_timer = '0;
            next_s.strength   = '0;
            next_s.mode       = (s.mode == PUMP_1X) ? PUMP_1P5X
                                                    : PUMP_2X;
          end
          else
            next_s.mode_timer = s.mode_timer + 1'b1;
        end
      end
      else if (!dropout)
        next_s.mode_timer = '0;
      if (s.mode != PUMP_1X && tick && s.strength < SOFT_FULL
          && next_s.strength != '0)
        next_s.strength = s.strength + 1'b1;
      else if (s.mode != PUMP_1X && tick && s.strength < SOFT_FULL
               && s.mode == next_s.mode)
        next_s.strength = s.strength + 1'b1;
    end

    // Sinks
    next_s.main_code = ch_main_code;
    next_s.cam_code  = ch_cam_code;
    next_s.sink_en   = (ch_main_code != DAC_OFF && !s.asleep)
                     ? ~tied : '0;
    next_s.test_cur  = s.asleep ? '0 : tied;

    // Pump switches
    next_s.bypass    = s.mode == PUMP_1X && !s.asleep
                     && !s.lvl[IDX_ABOVE_BAT];
    next_s.precharge = s.asleep;
    next_s.ref_en    = !s.asleep;
    // Phases already in flight must not close switches in shutdown
    next_s.series    = s.mode == PUMP_1P5X && ph1 && !s.asleep;
    next_s.parallel  = s.mode == PUMP_1P5X && ph2 && !s.asleep;
    next_s.cap1      = s.mode == PUMP_2X && ph1 && !s.asleep;
    next_s.cap2      = s.mode == PUMP_2X && ph2 && !s.asleep;
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      s           <= '0;
      s.asleep    <= 1'b1;
      s.precharge <= 1'b1;
      s.mode      <= PUMP_1X;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign main_dac_code          = s.main_code;
  assign main_sink_enable       = s.sink_en;
  assign main_sink_test_current = s.test_cur;
  assign cam_dac_code           = s.cam_code;
  assign pump_mode              = s.mode;
  assign pump_strength          = s.strength;
  assign battery_bypass         = s.bypass;
  assign caps_series_charge     = s.series;
  assign caps_parallel_stack    = s.parallel;
  assign flying_cap1_charge     = s.cap1;
  assign flying_cap2_charge     = s.cap2;
  assign shutdown               = s.asleep;
  assign weak_precharge         = s.precharge;
  assign reference_enable       = s.ref_en;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  a_sleep_one_x: assert property (
    s.asleep |=> s.mode == PUMP_1X && s.strength == '0)
    else $error("pump not in 1x during shutdown");
  a_cam_fall_mode: assert property (
    s.cam_line_d && !cam_line |=> s.mode == PUMP_1X)
    else $error("camera line fall did not reset mode");
  a_step_delay: assert property (
    s.mode != $past(s.mode) && s.mode != PUMP_1X
    |-> $past(s.mode_timer) == MODE_LAST && $past(tick) && $past(dropout))
    else $error("step-up without full dropout delay");
  a_step_order: assert property (
    $past(s.mode) == PUMP_1X && s.mode != PUMP_1X |-> s.mode == PUMP_1P5X)
    else $error("pump skipped the 1.5x step");
  a_bypass_guard: assert property (
    s.bypass |-> $past(!s.lvl[IDX_ABOVE_BAT] && s.mode == PUMP_1X))
    else $error("bypass closed above battery voltage");
  a_overcurrent_off: assert property (
    overcurrent |=> s.asleep ##2 s.main_code == DAC_OFF)
    else $error("overcurrent did not force shutdown");
  a_sleep_quiet: assert property (
    s.asleep ##1 s.asleep |-> s.precharge && !s.ref_en && s.sink_en == '0
    && !s.series && !s.parallel && !s.cap1 && !s.cap2)
    else $error("circuitry active in shutdown");
  a_idle_sleep: assert property (
    ch_main_idle && ch_cam_idle |=> s.asleep)
    else $error("idle lines did not enter shutdown");
  a_unused_sink: assert property (
    tied != '0 && !s.asleep |=> (s.sink_en & $past(tied)) == '0
    && (s.test_cur & $past(tied)) == $past(tied))
    else $error("tied sink still enabled");
  a_phase_excl: assert property (
    !(s.series && s.parallel) && !(s.cap1 && s.cap2)
    && !((s.series || s.parallel) && (s.cap1 || s.cap2)))
    else $error("flying capacitor phases overlap");
  a_soft_ramp: assert property (
    s.mode != $past(s.mode) && s.mode != PUMP_1X |-> s.strength == '0)
    else $error("step-up entered without soft start");
  a_ramp_step: assert property (
    s.strength != $past(s.strength) && s.strength != '0
    |-> s.strength == $past(s.strength) + 1'b1 && $past(tick))
    else $error("soft start ramp not linear");
  a_awake_ref: assert property (
    !s.asleep |=> s.ref_en && !s.precharge)
    else $error("reference off while awake");
  a_test_sleep: assert property (
    s.asleep |=> s.test_cur == '0 && !s.bypass)
    else $error("sink test current on in shutdown");

  c_step_15x: cover property (s.mode == PUMP_1X ##1 s.mode == PUMP_1P5X);
  c_step_2x: cover property (s.mode == PUMP_1P5X ##1 s.mode == PUMP_2X);
  c_wake_commit: cover property (s.wake ##1 s.main_code != DAC_OFF);
  c_shutdown: cover property (!s.asleep ##1 s.asleep);
  c_cam_fall: cover property (s.cam_line_d && !cam_line ##1 s.mode == PUMP_1X);

endmodule : led_pump_ctrl

// >>> hdl/led_pump_pkg.sv
/*
  Shared constants and types for the strobe-programmed LED driver control:
  clock rates, timer lengths in pump-clock ticks, DAC codes, input bit
  positions of the synchronised pin vector and the charge pump modes.
  Assumes a single 100 MHz system clock.
*/
package led_pump_pkg;

  // ----------------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_MHZ    = 100;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int PUMP_FREQ_KHZ   = 800;
  localparam int NONOVERLAP_NS   = 35;
  localparam int PUMP_PERIOD_CYC = CLK_FREQ_MHZ * 1000 / PUMP_FREQ_KHZ;
  localparam int NONOVERLAP_CYC  =
    (NONOVERLAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Timers, in pump-clock ticks
  // ----------------------------------------------------------------------
  localparam int COMMIT_US     = 150;
  localparam int WAKE_EXTRA_US = 100;
  localparam int MODE_DELAY_US = 400;
  localparam int SOFT_START_US = 150;
  localparam int COMMIT_TICKS  = COMMIT_US * PUMP_FREQ_KHZ / 1000;
  localparam int WAKE_TICKS    = WAKE_EXTRA_US * PUMP_FREQ_KHZ / 1000;
  localparam int MODE_TICKS    = MODE_DELAY_US * PUMP_FREQ_KHZ / 1000;
  localparam int SOFT_TICKS    = SOFT_START_US * PUMP_FREQ_KHZ / 1000;
  localparam int TIMER_W       = 9;
  localparam int STRENGTH_W    = 7;
  localparam int PHASE_CNT_W   = 8;

  // ----------------------------------------------------------------------
  // DAC codes: 0 is off, first strobe wraps to full scale, 1 is the LSB
  // ----------------------------------------------------------------------
  localparam int         DAC_W    = 3;
  localparam logic [2:0] DAC_OFF  = 3'h0;
  localparam logic [2:0] DAC_LSB  = 3'h1;
  localparam int         MAIN_SINKS = 4;

  // ----------------------------------------------------------------------
  // Bit positions in the synchronised input vector
  // ----------------------------------------------------------------------
  localparam int IDX_MAIN_EN   = 0;
  localparam int IDX_CAM_EN    = 1;
  localparam int IDX_MAIN_DROP = 2;
  localparam int IDX_CAM_DROP  = 6;
  localparam int IDX_MAIN_OVC  = 7;
  localparam int IDX_CAM_OVC   = 8;
  localparam int IDX_ABOVE_BAT = 9;
  localparam int IDX_TIED      = 10;
  localparam int IN_W          = 14;

  typedef enum logic [1:0] {PUMP_1X, PUMP_1P5X, PUMP_2X} pump_mode_t;

endpackage : led_pump_pkg

// >>> hdl/pump_phase_gen.sv
/*
  Two-phase nonoverlapping pump clock divided from the system clock, plus a
  one-cycle tick per pump period that times the slow control delays.
  Assumes the system clock of the package; phases stop while run is low.
*/
module pump_phase_gen
  import led_pump_pkg::*;
#(
  parameter int PERIOD = PUMP_PERIOD_CYC,
  parameter int DEAD   = NONOVERLAP_CYC
)
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // Control
  input  wire logic run,
  // Phases and tick
  output logic      phase1,
  output logic      phase2,
  output logic      tick
);
  import led_pump_pkg::*;

  localparam logic [PHASE_CNT_W-1:0] LAST  = PHASE_CNT_W'(PERIOD - 1);
  localparam logic [PHASE_CNT_W-1:0] HALF  = PHASE_CNT_W'(PERIOD / 2);
  localparam logic [PHASE_CNT_W-1:0] DEADC = PHASE_CNT_W'(DEAD);

  typedef struct packed {
    logic [PHASE_CNT_W-1:0] cnt;
    logic                   ph1;
    logic                   ph2;
    logic                   tick;
  } phase_state_t;

  phase_state_t s;
  phase_state_t next_s;

  // ----------------------------------------------------------------------
  // Divider and phase windows with dead time on both sides
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_s      = s;
    next_s.cnt  = (s.cnt == LAST) ? '0 : s.cnt + 1'b1;
    next_s.tick = (s.cnt == LAST);
    next_s.ph1  = run && s.cnt >= DEADC && s.cnt < HALF;
    next_s.ph2  = run && s.cnt >= HALF + DEADC && s.cnt < LAST;
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
      s <= '0;
    else
      s <= next_s;
  end

  assign phase1 = s.ph1;
  assign phase2 = s.ph2;
  assign tick   = s.tick;

endmodule : pump_phase_gen

// >>> hdl/strobe_channel.sv
/*
  One strobe-programmed current channel: down counter, commit timer, idle
  timer that resets the counter, and the applied DAC code.
  Assumes line is already synchronised and tick is one cycle per pump period.
*/
module strobe_channel
  import led_pump_pkg::*;
#(
  parameter int COMMIT = COMMIT_TICKS,
  parameter int WAKE   = WAKE_TICKS
)
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  // Control
  input  wire logic             line,
  input  wire logic             tick,
  input  wire logic             extra_delay,
  input  wire logic             force_off,
  // Status
  output logic [DAC_W-1:0]      dac_code,
  output logic                  idle_long
);
  import led_pump_pkg::*;

  localparam logic [TIMER_W-1:0] LIM_NORM = TIMER_W'(COMMIT);
  localparam logic [TIMER_W-1:0] LIM_WAKE = TIMER_W'(COMMIT + WAKE);

  typedef struct packed {
    logic               line_d;
    logic [DAC_W-1:0]   count;
    logic [DAC_W-1:0]   code;
    logic [TIMER_W-1:0] timer;
    logic               idle;
  } chan_state_t;

  chan_state_t s;
  chan_state_t next_s;
  logic [TIMER_W-1:0] limit;

  // ----------------------------------------------------------------------
  // Counting, commit and idle reset
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_s        = s;
    limit         = extra_delay ? LIM_WAKE : LIM_NORM;
    next_s.line_d = line;
    if (line != s.line_d)
      next_s.timer = '0;
    else if (tick && s.timer != '1)
      next_s.timer = s.timer + 1'b1;
    if (line && !s.line_d)
      next_s.count = (s.count == DAC_LSB) ? DAC_LSB
                                          : s.count - 3'h1;
    // On an edge cycle the timer still holds the old level's time
    if (!line)
    begin
      next_s.code = DAC_OFF;
      if (line == s.line_d && s.timer >= LIM_NORM)
      begin
        next_s.count = DAC_OFF;
        next_s.idle  = 1'b1;
      end
    end
    else
    begin
      next_s.idle = 1'b0;
      if (line == s.line_d && s.timer >= limit)
        next_s.code = s.count;
    end
    if (force_off)
      next_s.code = DAC_OFF;
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      s      <= '0;
      s.idle <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign dac_code  = s.code;
  assign idle_long = s.idle;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  a_count_floor: assert property (
    line && !s.line_d && s.count == DAC_LSB |=> s.count == DAC_LSB)
    else $error("counter left the LSB");
  a_count_step: assert property (
    line && !s.line_d && s.count != DAC_LSB && !(s.timer >= LIM_NORM && 1'b0)
    |=> s.count == $past(s.count) - 3'h1)
    else $error("rising strobe did not decrement");
  a_low_zero: assert property (
    !line |=> s.code == DAC_OFF)
    else $error("low line left current on");
  a_late_commit: assert property (
    s.code != DAC_OFF && $past(s.code) != s.code
    |-> $past(line) && $past(s.timer) >= LIM_NORM)
    else $error("setting applied before the commit delay");
  a_idle_reset: assert property (
    !line && s.line_d == line && s.timer >= LIM_NORM |=> s.count == DAC_OFF)
    else $error("counter not reset after idle time");

endmodule : strobe_channel

// >>> testbench/strobe_host.sv
/*
  Host model driving the main and camera strobe enable lines.
  Assumes the bench clock; lines change on falling edges only.
*/
module strobe_host
(
  // Clock
  input  wire logic clock,
  // Strobe lines
  output logic      main_line,
  output logic      cam_line
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    main_line = 1'b0;
    cam_line  = 1'b0;
  end

  // Sets one line; the caller keeps to falling edges
  task automatic drive(input bit cam, input logic val);
    if (cam)
      cam_line = val;
    else
      main_line = val;
  endtask : drive

  // Six cycles low then six high per strobe; line left high
  task automatic strobe(input bit cam, input int n);
    repeat (n)
    begin
      drive(cam, 1'h0);
      repeat (6) @(negedge clock);
      drive(cam, 1'h1);
      repeat (6) @(negedge clock);
    end
  endtask : strobe
endmodule : strobe_host

// >>> testbench/strobe_led_current_and_pump_mode_control_tb_top.sv
/*
  Self-checking bench for the LED driver control with shortened timers.
  Assumes strobe_host drives the two lines; comparators driven here.
*/
module strobe_led_current_and_pump_mode_control_tb_top;
  import led_pump_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clock, rstn, cdrop, movc, covc, above, sd, wp;
  logic       mline, cline, bypass, ser, par, c1, c2, ref_en;
  logic [3:0] mdrop, tied, men, mtest;
  logic [2:0] mcode, ccode;
  logic [6:0] strength;
  pump_mode_t mode;
  int         error_cnt, compares;

  strobe_host i_host (.clock(clock), .main_line(mline), .cam_line(cline));

  led_pump_ctrl #(.PUMP_PERIOD(12), .COMMIT(4), .WAKE(2),
    .MODE_DELAY(4), .SOFT_START(4)) i_dut (
    .clock(clock), .rstn(rstn),
    .main_strobe_enable(mline),
    .cam_strobe_enable(cline),
    .main_sink_dropout(mdrop), .cam_sink_dropout(cdrop),
    .main_set_overcurrent(movc), .cam_set_overcurrent(covc),
    .pump_output_above_battery(above), .main_sink_tied_to_pump(tied),
    .main_dac_code(mcode), .main_sink_enable(men),
    .main_sink_test_current(mtest), .cam_dac_code(ccode),
    .pump_mode(mode), .pump_strength(strength), .battery_bypass(bypass),
    .caps_series_charge(ser), .caps_parallel_stack(par),
    .flying_cap1_charge(c1), .flying_cap2_charge(c2),
    .shutdown(sd), .weak_precharge(wp), .reference_enable(ref_en));

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [7:0] pick(input int s);
    case (s)
      0: pick = {5'h00, mcode};
      1: pick = {5'h00, ccode};
      2: pick = {6'h00, mode};
      4: pick = {1'h0, strength};
      5: pick = {7'h00, bypass};
      6: pick = {4'h0, c2, c1, par, ser};
      7: pick = {7'h00, ref_en};
      default: pick = {7'h00, sd};
    endcase
  endfunction : pick

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Bounded wait for a watched output, then compare
  task automatic wait_chk(input int s, input logic [7:0] exp);
    for (int i = 0; i < 400 && pick(s) !== exp; i++) @(negedge clock);
    check(pick(s), exp);
  endtask : wait_chk

  task automatic end_sim;
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_main;
    i_host.strobe(0, 1);
    wait_chk(0, 8'h07);
    check({4'h0, men}, 8'h07);
    check({4'h0, mtest}, 8'h08);
    check(pick(5), 8'h01);
    check(pick(7), 8'h01);
    i_host.strobe(0, 2);
    check(pick(0), 8'h00);
    wait_chk(0, 8'h05);
    i_host.strobe(0, 8);
    wait_chk(0, 8'h01);
  endtask : t_main

  task automatic t_cam;
    i_host.strobe(1, 3);
    wait_chk(1, 8'h05);
    i_host.strobe(1, 1);
    wait_chk(1, 8'h04);
  endtask : t_cam

  task automatic t_pump;
    mdrop = 4'h1;
    repeat (36) @(negedge clock);
    check(pick(2), 8'h00);
    wait_chk(2, 8'h01);
    check(pick(4), 8'h00);
    wait_chk(6, 8'h01);
    wait_chk(6, 8'h02);
    wait_chk(2, 8'h02);
    check(pick(5), 8'h00);
    wait_chk(4, 8'h04);
    wait_chk(6, 8'h04);
    wait_chk(6, 8'h08);
    mdrop = 4'h0;
    i_host.drive(1, 1'h0);
    wait_chk(2, 8'h00);
    wait_chk(1, 8'h00);
    wait_chk(5, 8'h01);
    above = 1'h1;
    wait_chk(5, 8'h00);
    above = 1'h0;
    wait_chk(5, 8'h01);
  endtask : t_pump

  task automatic t_idle;
    i_host.drive(0, 1'h0);
    wait_chk(0, 8'h00);
    wait_chk(3, 8'h01);
    @(negedge clock);
    check({7'h00, wp}, 8'h01);
    check(pick(7), 8'h00);
    i_host.strobe(0, 1);
    repeat (52) @(negedge clock);
    check(pick(0), 8'h00);
    wait_chk(0, 8'h07);
    movc = 1'b1;
    wait_chk(3, 8'h01);
    wait_chk(0, 8'h00);
    movc = 1'b0;
  endtask : t_idle

  initial
  begin
    {rstn, cdrop, movc, covc, above, mdrop} = '0;
    tied = 4'h8;
    repeat (4) @(negedge clock);
    rstn = 1'b1;
    check(pick(3), 8'h01);
    check(pick(2), 8'h00);
    t_main();
    t_cam();
    t_pump();
    t_idle();
    end_sim();
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    end_sim();
  end
endmodule : strobe_led_current_and_pump_mode_control_tb_top
